// ### design/isa_pkg.sv
// Overview of operation
// - a sync orders selected loads and stores identically for every processor
// - an exception aborts the instruction; its operation never resumes
// - nullify aborts; a not-taken likely branch kills its delay slot
// - coprocessor op sends function field to the selected coprocessor unit
// - flag jump delay slot right after register jump, link jumps or exchange jump
// - value is not a word when any bit 63..32 differs from bit 31
// - condition code read: index 0 gives bit 23, else bit 24 plus index
// - condition code write replaces only the selected bit, others unchanged
// - every integer instruction is implemented, none omitted
// - fpu may be omitted; presence shown by fpu_present_flag in feature_config_first
// - fpu subsets: none, s/d/w/l, or s/d/w/l plus optional paired single
// - fp_implementation_reg bits report the implemented floating data types
// - coprocessor 2 may be omitted; shown by cop2_present_flag in feature_config_first
// - each coprocessor 2 interface instruction may be omitted individually
// - reserved or zero instruction fields carry no meaning for the core; a sync with bits 25..11 nonzero raises reserved instruction
// - extensions optional, reported in feature_config_first or feature_config_third
// - an omitted instruction raises reserved instruction or coprocessor unusable
// - additions only as secondary_special_opcode functions or coprocessor 2 instructions
package isa_pkg;
  // register bus
  localparam int          ADR_W          = 5;
  localparam logic [4:0]  OFS_FP_CSR     = 5'h00;
  localparam logic [4:0]  OFS_CORE_CTRL  = 5'h04;
  localparam logic [4:0]  OFS_CFG_FIRST  = 5'h08;
  localparam logic [4:0]  OFS_CFG_THIRD  = 5'h0c;
  localparam logic [4:0]  OFS_FP_IMPL    = 5'h10;
  localparam logic [4:0]  OFS_CORE_STAT  = 5'h14;
  // reset values
  localparam logic [31:0] FP_CONTROL_STATUS_RST       = 32'h0000_0000;
  localparam logic [1:0]  CTRL_RST       = 2'h3;
  // field positions
  localparam int          CC0_BIT        = 23;
  localparam int          CC_HI_BASE     = 24;
  localparam int          CFG1_FPU_BIT   = 0;
  localparam int          CFG1_COP2_BIT  = 6;
  localparam int          FIR_S_BIT      = 16;
  localparam int          FIR_D_BIT      = 17;
  localparam int          FIR_PAIRED_BIT = 18;
  localparam int          FIR_W_BIT      = 20;
  localparam int          FIR_L_BIT      = 21;
  localparam int          CTRL_CU1_BIT   = 0;
  localparam int          CTRL_CU2_BIT   = 1;
  localparam int          STAT_SYNC_BIT  = 0;
  localparam int          STAT_SLOT_BIT  = 1;
  localparam int          STAT_EXC_LSB   = 8;
  // major opcodes and functions
  localparam logic [5:0]  OP_SPECIAL     = 6'h00;
  localparam logic [5:0]  OP_REGIMM      = 6'h01;
  localparam logic [5:0]  OP_JUMP_AND_LINK = 6'h03;
  localparam logic [5:0]  OP_COP1        = 6'h11;
  localparam logic [5:0]  OP_COP2        = 6'h12;
  localparam logic [5:0]  OP_COP1X       = 6'h13;
  localparam logic [5:0]  OP_SECONDARY_SPECIAL = 6'h1c;
  localparam logic [5:0]  OP_JUMP_LINK_EXCHANGE = 6'h1d;
  localparam logic [5:0]  OP_LWC1        = 6'h31;
  localparam logic [5:0]  OP_LDC1        = 6'h35;
  localparam logic [5:0]  OP_SWC1        = 6'h39;
  localparam logic [5:0]  OP_SDC1        = 6'h3d;
  localparam logic [5:0]  OP_LWC2        = 6'h32;
  localparam logic [5:0]  OP_LDC2        = 6'h36;
  localparam logic [5:0]  OP_SWC2        = 6'h3a;
  localparam logic [5:0]  OP_SDC2        = 6'h3e;
  localparam logic [5:0]  FN_JUMP_VIA_REGISTER      = 6'h08;
  localparam logic [5:0]  FN_JUMP_LINK_VIA_REGISTER = 6'h09;
  localparam logic [5:0]  FN_SYNC        = 6'h0f;
  localparam logic [5:0]  FN_FP_COND_MOVE = 6'h01;
  localparam logic [4:0]  RS_BRANCH      = 5'h08;
  localparam logic [4:0]  RS_MF          = 5'h00;
  localparam logic [4:0]  RS_DMF         = 5'h01;
  localparam logic [4:0]  RS_CF          = 5'h02;
  localparam logic [4:0]  RS_MT          = 5'h04;
  localparam logic [4:0]  RS_DMT         = 5'h05;
  localparam logic [4:0]  RS_CT          = 5'h06;
  localparam logic [4:0]  FMT_PAIRED     = 5'h16;
  // legal encodings, one bit per code
  localparam logic [63:0] MAJOR_LEGAL     = 64'hf7ef_ffff_3fff_ffff;
  localparam logic [63:0] SPECIAL_LEGAL   = 64'hdd5f_fcff_ffdf_bfdf;
  localparam logic [63:0] SECONDARY_LEGAL = 64'h8000_0033_0000_0037;
  // exception codes
  localparam logic [4:0]  EXC_RI         = 5'h0a;
  localparam logic [4:0]  EXC_CPU        = 5'h0b;
  // coprocessor 2 interface instruction classes
  localparam int          COP2_CLASSES   = 12;
  localparam logic [3:0]  C2_BRANCH = 4'h0, C2_CF = 4'h1, C2_OPERATE = 4'h2, C2_CT = 4'h3;
  localparam logic [3:0]  C2_DMF = 4'h4, C2_DMT = 4'h5, C2_LD = 4'h6, C2_LW = 4'h7;
  localparam logic [3:0]  C2_MF = 4'h8, C2_MT = 4'h9, C2_SD = 4'ha, C2_SW = 4'hb;
  typedef enum logic [1:0] {SYNC_IDLE = 2'b01, SYNC_WAIT = 2'b10} sync_state_t;
endpackage : isa_pkg

// ### design/isa_decode.sv
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module isa_decode #(
  parameter bit          FPU_PRESENT        = 1'b1,
  parameter bit          PAIRED_PRESENT     = 1'b1,
  parameter bit          COP2_PRESENT       = 1'b1,
  parameter logic [11:0] COP2_OMIT          = 12'h000,
  parameter logic [63:0] SECONDARY_EXT_MASK = 64'h0,
  parameter logic [31:0] ASE_FIRST          = 32'h0,
  parameter logic [31:0] ASE_THIRD          = 32'h0
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // wishbone slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [isa_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  // instruction issue
  input  wire logic                        instr_valid,
  input  wire logic [31:0]                 instr,
  input  wire logic [63:0]                 operand,
  input  wire logic                        likely_not_taken,
  input  wire logic                        compare_result,
  output logic                             instr_ready,
  // decode results
  output logic                             dec_valid,
  output logic                             in_jump_slot,
  output logic                             nullified,
  output logic                             not_word,
  output logic                             condition_value,
  output logic                             exc_valid,
  output logic      [4:0]                  exc_code,
  output logic      [1:0]                  exc_unit,
  // coprocessor dispatch
  output logic                             cop_valid,
  output logic      [1:0]                  cop_unit,
  output logic      [24:0]                 cop_func,
  // memory ordering
  output logic                             sync_req,
  output logic      [4:0]                  sync_type,
  input  wire logic                        sync_done
);
  import isa_pkg::*;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [31:0] fp_control_status;
    logic [1:0]  ctrl;
    logic        prev_jump;
    logic        prev_likely;
    sync_state_t sync_st;
    logic [4:0]  sync_type;
    logic        dec_valid;
    logic        in_jump_slot;
    logic        nullified;
    logic        not_word;
    logic        cond_val;
    logic        exc_valid;
    logic [4:0]  exc_code;
    logic [1:0]  exc_unit;
    logic [4:0]  last_exc;
    logic        cop_valid;
    logic [1:0]  cop_unit;
    logic [24:0] cop_func;
  } state_t;

  state_t st;
  state_t next_st;

  function automatic logic fcc_read(input logic [31:0] csr, input logic [2:0] idx);
    // condition code 0 sits apart from codes 1..7
    if (idx == 3'h0)
      return csr[CC0_BIT];
    return csr[CC_HI_BASE + int'(idx)];
  endfunction : fcc_read

  function automatic logic [31:0] fcc_write(input logic [31:0] csr, input logic [2:0] idx,
                                            input logic val);
    logic [31:0] r;
    r = csr;
    if (idx == 3'h0)
      r[CC0_BIT] = val;
    else
      r[CC_HI_BASE + int'(idx)] = val;
    return r;
  endfunction : fcc_write

  function automatic logic is_jump(input logic [31:0] w);
    return (w[31:26] == OP_JUMP_AND_LINK) || (w[31:26] == OP_JUMP_LINK_EXCHANGE) ||
           ((w[31:26] == OP_SPECIAL) &&
            ((w[5:0] == FN_JUMP_VIA_REGISTER) || (w[5:0] == FN_JUMP_LINK_VIA_REGISTER)));
  endfunction : is_jump

  function automatic logic is_likely(input logic [31:0] w);
    logic cop_br;
    cop_br = ((w[31:26] == OP_COP1) || (w[31:26] == OP_COP2)) && (w[25:21] == RS_BRANCH) && w[17];
    return (w[31:28] == 4'h5) || cop_br ||
           ((w[31:26] == OP_REGIMM) && (w[19:17] == 3'h1));
  endfunction : is_likely

  function automatic logic [3:0] cop2_class(input logic [31:0] w);
    logic [3:0] c;
    c = C2_OPERATE;
    unique case (w[31:26])
      OP_LWC2: c = C2_LW;
      OP_LDC2: c = C2_LD;
      OP_SWC2: c = C2_SW;
      OP_SDC2: c = C2_SD;
      default:
      begin
        if (!w[25])
        begin
          if (w[25:21] == RS_BRANCH) c = C2_BRANCH;
          else if (w[25:21] == RS_CF) c = C2_CF;
          else if (w[25:21] == RS_CT) c = C2_CT;
          else if (w[25:21] == RS_MF) c = C2_MF;
          else if (w[25:21] == RS_MT) c = C2_MT;
          else if (w[25:21] == RS_DMF) c = C2_DMF;
          else if (w[25:21] == RS_DMT) c = C2_DMT;
        end
      end
    endcase
    return c;
  endfunction : cop2_class

  function automatic logic [31:0] apply_sel(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i]) r[8*i +: 8] = wd[8*i +: 8];
    return r;
  endfunction : apply_sel

  // feature reports are wired from the build options
  logic [31:0] cfg_first;
  logic [31:0] cfg_third;
  logic [31:0] fp_impl;
  always_comb
  begin
    cfg_first = ASE_FIRST;
    fp_impl   = 32'h0;
    cfg_first[CFG1_FPU_BIT]  = FPU_PRESENT;
    cfg_first[CFG1_COP2_BIT] = COP2_PRESENT;
    cfg_third = ASE_THIRD;
    fp_impl[FIR_S_BIT]      = FPU_PRESENT;
    fp_impl[FIR_D_BIT]      = FPU_PRESENT;
    fp_impl[FIR_W_BIT]      = FPU_PRESENT;
    fp_impl[FIR_L_BIT]      = FPU_PRESENT;
    fp_impl[FIR_PAIRED_BIT] = FPU_PRESENT && PAIRED_PRESENT;
  end

  logic [5:0] op;
  logic [5:0] fn;
  logic       accept;
  logic       bus_req;
  logic       bus_wr;
  logic       is_fpu;
  logic       is_cop2;
  logic       is_cmp;
  logic       raise;
  logic [4:0] code;
  logic [1:0] unit;
  logic       killed;

  assign op      = instr[31:26];
  assign fn      = instr[5:0];
  assign accept  = instr_valid && instr_ready;
  assign bus_req = wb_cyc_i && wb_stb_i && !st.ack;
  assign bus_wr  = bus_req && wb_we_i;
  assign is_fpu  = (op == OP_COP1) || (op == OP_COP1X) || (op == OP_LWC1) || (op == OP_LDC1) ||
                   (op == OP_SWC1) || (op == OP_SDC1) || ((op == OP_SPECIAL) && (fn == FN_FP_COND_MOVE));
  assign is_cop2 = (op == OP_COP2) || (op == OP_LWC2) || (op == OP_LDC2) ||
                   (op == OP_SWC2) || (op == OP_SDC2);
  assign is_cmp  = (op == OP_COP1) && instr[25] && (fn[5:4] == 2'b11);
  // delay slot of a not-taken likely branch
  assign killed  = st.prev_likely && likely_not_taken;

  // exception decision, most basic check first
  always_comb
  begin
    raise = 1'b1;
    code  = EXC_RI;
    unit  = 2'h0;
    if (!MAJOR_LEGAL[op] || ((op == OP_SPECIAL) && !SPECIAL_LEGAL[fn]))
      code = EXC_RI;
    else if ((op == OP_SPECIAL) && (fn == FN_SYNC) && (instr[25:11] != 15'h0))
      code = EXC_RI;
    else if ((op == OP_SECONDARY_SPECIAL) && !(SECONDARY_LEGAL[fn] || SECONDARY_EXT_MASK[fn]))
      code = EXC_RI;
    else if (is_fpu && (!FPU_PRESENT || !st.ctrl[CTRL_CU1_BIT]))
    begin
      code = EXC_CPU;
      unit = 2'h1;
    end
    else if ((op == OP_COP1) && (instr[25:21] == FMT_PAIRED) && !PAIRED_PRESENT)
      code = EXC_RI;
    else if (is_cop2 && (!COP2_PRESENT || !st.ctrl[CTRL_CU2_BIT]))
    begin
      code = EXC_CPU;
      unit = 2'h2;
    end
    else if (is_cop2 && COP2_OMIT[cop2_class(instr)])
      code = EXC_RI;
    else
      raise = 1'b0;
  end

  always_comb
  begin
    next_st           = st;
    next_st.ack       = bus_req;
    next_st.dec_valid = accept;
    next_st.exc_valid = 1'b0;
    next_st.cop_valid = 1'b0;
    next_st.nullified = 1'b0;
    // register bus, unmapped reads give zero
    if (bus_req)
    begin
      unique case (wb_adr_i)
        OFS_FP_CSR:    next_st.rdata = st.fp_control_status;
        OFS_CORE_CTRL: next_st.rdata = {30'h0, st.ctrl};
        OFS_CFG_FIRST: next_st.rdata = cfg_first;
        OFS_CFG_THIRD: next_st.rdata = cfg_third;
        OFS_FP_IMPL:   next_st.rdata = fp_impl;
        OFS_CORE_STAT: next_st.rdata = {19'h0, st.last_exc, 6'h0, st.prev_jump,
                                        st.sync_st == SYNC_WAIT};
        default:       next_st.rdata = 32'h0;
      endcase
      if (bus_wr && (wb_adr_i == OFS_FP_CSR))
        next_st.fp_control_status = apply_sel(st.fp_control_status, wb_dat_i, wb_sel_i);
      if (bus_wr && (wb_adr_i == OFS_CORE_CTRL) && wb_sel_i[0])
        next_st.ctrl = wb_dat_i[1:0];
    end
    // hold the ordering request until the memory side completes
    if ((st.sync_st == SYNC_WAIT) && sync_done)
      next_st.sync_st = SYNC_IDLE;
    if (accept)
    begin
      next_st.not_word     = operand[63:32] != {32{operand[31]}};
      next_st.cond_val     = fcc_read(st.fp_control_status, instr[20:18]);
      // previous accepted instruction was a jump
      next_st.in_jump_slot = st.prev_jump;
      next_st.prev_jump    = 1'b0;
      next_st.prev_likely  = 1'b0;
      if (killed)
        // delay slot nullified, no side effect
        next_st.nullified = 1'b1;
      else if (raise)
      begin
        // abort: nothing of the instruction proceeds
        next_st.exc_valid = 1'b1;
        next_st.exc_code  = code;
        next_st.exc_unit  = unit;
        next_st.last_exc  = code;
      end
      else
      begin
        next_st.prev_jump   = is_jump(instr);
        next_st.prev_likely = is_likely(instr);
        if ((op[5:2] == 4'h4) && instr[25])
        begin
          next_st.cop_valid = 1'b1;
          next_st.cop_unit  = op[1:0];
          next_st.cop_func  = instr[24:0];
        end
        // update one condition bit on top of any bus write
        if (is_cmp)
          next_st.fp_control_status = fcc_write(next_st.fp_control_status, instr[10:8], compare_result);
        // start ordering, stalls issue until done
        if ((op == OP_SPECIAL) && (fn == FN_SYNC))
        begin
          next_st.sync_st   = SYNC_WAIT;
          next_st.sync_type = instr[10:6];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st         <= '0;
      st.fp_control_status    <= FP_CONTROL_STATUS_RST;
      st.ctrl    <= CTRL_RST;
      st.sync_st <= SYNC_IDLE;
    end
    else
      st <= next_st;
  end

  // no issue while an ordering request is open
  assign instr_ready     = st.sync_st == SYNC_IDLE;
  assign wb_ack_o        = st.ack;
  assign wb_dat_o        = st.rdata;
  assign dec_valid       = st.dec_valid;
  assign in_jump_slot    = st.in_jump_slot;
  assign nullified       = st.nullified;
  assign not_word        = st.not_word;
  assign condition_value = st.cond_val;
  assign exc_valid       = st.exc_valid;
  assign exc_code        = st.exc_code;
  assign exc_unit        = st.exc_unit;
  assign cop_valid       = st.cop_valid;
  assign cop_unit        = st.cop_unit;
  assign cop_func        = st.cop_func;
  assign sync_req        = st.sync_st == SYNC_WAIT;
  assign sync_type       = st.sync_type;

  default clocking dcb @(posedge clk); endclocking
  default disable iff (rst);

  property p_sync_hold;
    sync_req && !sync_done |=> sync_req && (sync_type == $past(sync_type)) && !instr_ready;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync request dropped early");
  property p_exc_abort;
    exc_valid |-> !cop_valid && !nullified && dec_valid;
  endproperty
  a_exc_abort: assert property (p_exc_abort) else $error("aborted instruction had effect");
  property p_null_kill;
    accept && st.prev_likely && likely_not_taken |=> nullified && !exc_valid && !cop_valid;
  endproperty
  a_null_kill: assert property (p_null_kill) else $error("delay slot not nullified");
  property p_cop_dispatch;
    cop_valid |-> (cop_func == $past(instr[24:0])) && (cop_unit == $past(instr[27:26]));
  endproperty
  a_cop_dispatch: assert property (p_cop_dispatch) else $error("wrong coprocessor dispatch");
  property p_jump_slot;
    (accept && is_jump(instr) && !raise && !killed) ##1 accept |=> in_jump_slot;
  endproperty
  a_jump_slot: assert property (p_jump_slot) else $error("jump slot not flagged");
  property p_not_word;
    dec_valid |-> not_word == ($past(operand[63:32]) != {32{$past(operand[31])}});
  endproperty
  a_not_word: assert property (p_not_word) else $error("word check wrong");
  property p_cc_read;
    dec_valid |-> condition_value == fcc_read($past(st.fp_control_status), $past(instr[20:18]));
  endproperty
  a_cc_read: assert property (p_cc_read) else $error("condition read wrong");
  property p_cc_write;
    accept && is_cmp && !raise && !killed && !bus_wr |=> $countones(st.fp_control_status ^ $past(st.fp_control_status)) <= 1;
  endproperty
  a_cc_write: assert property (p_cc_write) else $error("condition write touched other bits");
  property p_fpu_unusable;
    accept && is_fpu && !killed && MAJOR_LEGAL[op] && !st.ctrl[CTRL_CU1_BIT] |=>
      exc_valid && (exc_code == EXC_CPU) && (exc_unit == 2'h1);
  endproperty
  a_fpu_unusable: assert property (p_fpu_unusable) else $error("fpu use not trapped");
  property p_illegal_major;
    accept && !killed && !MAJOR_LEGAL[op] |=> exc_valid && (exc_code == EXC_RI);
  endproperty
  a_illegal_major: assert property (p_illegal_major) else $error("illegal opcode accepted");
  property p_bus_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus ack timing wrong");

  c_sync_done: cover property (sync_req ##[1:20] !sync_req);
  c_jump_slot: cover property (dec_valid && in_jump_slot);
  c_nullify:   cover property (nullified);
  c_cop_op:    cover property (cop_valid && (cop_unit == 2'h2));
endmodule : isa_decode
`default_nettype wire

// ### verif/sync_partner.sv
`timescale 1ns/1ps
`default_nettype none
module sync_partner (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // ordering handshake
  input  wire logic        sync_req,
  input  wire logic [4:0]  sync_type,
  input  wire logic [3:0]  done_delay,
  output logic             sync_done,
  // coprocessor dispatch
  input  wire logic        cop_valid,
  input  wire logic [1:0]  cop_unit,
  input  wire logic [24:0] cop_func
);
  logic [3:0]  wait_cnt;
  logic [4:0]  last_type;
  logic [24:0] last_func [4];
  // drain, then release
  // every ordering type gets the same full drain, so no type can be under-served
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      wait_cnt  <= 4'h0;
      sync_done <= 1'b0;
      last_type <= 5'h00;
    end
    else
    begin
      sync_done <= sync_req && !sync_done && wait_cnt >= done_delay;
      wait_cnt  <= (sync_req && !sync_done) ? wait_cnt + 4'h1 : 4'h0;
      last_type <= sync_req ? sync_type : last_type;
    end
  always_ff @(posedge clk)
    if (cop_valid)
      last_func[cop_unit] <= cop_func;
endmodule : sync_partner
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import isa_pkg::*;
  typedef struct packed {logic slot; logic nul; logic nw; logic cv; logic exc; logic [4:0] code; logic [1:0] eu;
    logic cop; logic [1:0] cu; logic [24:0] fn; logic syn; logic [4:0] st;} exp_t;
  logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, instr_valid, likely_not_taken, compare_result;
  logic instr_ready, dec_valid, in_jump_slot, nullified, not_word, condition_value, exc_valid;
  logic cop_valid, sync_req, sync_done, prev_jump;
  logic [4:0]  wb_adr_i, exc_code, sync_type;
  logic [3:0]  wb_sel_i, dly;
  logic [31:0] wb_dat_i, wb_dat_o, instr, fp_control_status_m, r, w;
  logic [63:0] operand;
  logic [1:0]  exc_unit, cop_unit;
  logic [24:0] cop_func;
  logic [31:0] jt [4] = '{32'h0000_0008, 32'h0c00_0000, 32'h0000_0009, 32'h7400_0000};
  exp_t        q [$];
  exp_t        em;
  int          n_mismatch, n_compared;
  integer      seed;
  isa_decode u_dut (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .instr_valid(instr_valid), .instr(instr), .operand(operand), .likely_not_taken(likely_not_taken),
    .compare_result(compare_result), .instr_ready(instr_ready), .dec_valid(dec_valid),
    .in_jump_slot(in_jump_slot), .nullified(nullified), .not_word(not_word), .condition_value(condition_value),
    .exc_valid(exc_valid), .exc_code(exc_code), .exc_unit(exc_unit), .cop_valid(cop_valid),
    .cop_unit(cop_unit), .cop_func(cop_func), .sync_req(sync_req), .sync_type(sync_type), .sync_done(sync_done));
  sync_partner u_partner (.clk(clk), .rst(rst), .sync_req(sync_req), .sync_type(sync_type), .done_delay(dly),
    .sync_done(sync_done), .cop_valid(cop_valid), .cop_unit(cop_unit), .cop_func(cop_func));
  always #50 clk = ~clk;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask : chk
  function automatic logic ccbit(input logic [31:0] f, input logic [2:0] c);
    return (c == 3'h0) ? f[CC0_BIT] : f[CC_HI_BASE + c];
  endfunction : ccbit
  // master holds the request until ack is seen at a rising edge
  task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d, output logic [31:0] rd);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk);
  endtask : wb
  task automatic rdchk(input logic [4:0] a, input logic [31:0] want);
    logic [31:0] rd;
    wb(1'b0, a, 32'h0, rd);
    chk("register read", rd, want);
  endtask : rdchk
  // offers one instruction, notes the expected result once it is taken
  task automatic issue(input logic [31:0] i, input logic [63:0] opd, input logic lnt, input logic cr,
                       input logic [7:0] xe);
    exp_t e;
    int   p;
    {instr_valid, instr, operand, likely_not_taken, compare_result} <= {1'b1, i, opd, lnt, cr};
    do @(posedge clk); while (instr_ready !== 1'b1);
    e.slot = prev_jump;
    e.nul = lnt;
    e.nw = opd[63:32] != {32{opd[31]}};
    e.cv = ccbit(fp_control_status_m, i[20:18]);
    {e.exc, e.code, e.eu} = xe;
    e.cop = !lnt && !xe[7] && i[31:28] == 4'h4 && i[25];
    {e.cu, e.fn} = {i[27:26], i[24:0]};
    e.syn = !lnt && !xe[7] && i[31:26] == OP_SPECIAL && i[5:0] == FN_SYNC;
    e.st = i[10:6];
    q.push_back(e);
    prev_jump = !lnt && !xe[7] && (i[31:26] == OP_JUMP_AND_LINK || i[31:26] == OP_JUMP_LINK_EXCHANGE
                || (i[31:26] == OP_SPECIAL && i[5:1] == 5'h04));
    p = (i[10:8] == 3'h0) ? CC0_BIT : CC_HI_BASE + i[10:8];
    if (e.cop && i[31:26] == OP_COP1 && i[5:4] == 2'b11)
      fp_control_status_m[p] = cr;
  endtask : issue
  task automatic idle;
    instr_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : idle
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // results are settled by the falling edge
  always @(negedge clk)
    if (dec_valid === 1'b1)
    begin
      em = q.pop_front();
      chk("in_jump_slot", in_jump_slot, em.slot);
      chk("nullified", nullified, em.nul);
      chk("not_word", not_word, em.nw);
      chk("condition_value", condition_value, em.cv);
      chk("exc_valid", exc_valid, em.exc);
      if (em.exc) chk("exc_code_unit", {exc_code, exc_unit}, {em.code, em.eu});
      chk("cop_valid", cop_valid, em.cop);
      if (em.cop) chk("cop_unit_func", {cop_unit, cop_func}, {em.cu, em.fn});
      if (em.syn) chk("sync_req_type", {sync_req, sync_type}, {1'b1, em.st});
    end
  initial
  begin
    #2000000;
    n_mismatch++;
    wrap_up();
  end
  initial
  begin
    {clk, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, instr_valid, instr, operand} = '0;
    {likely_not_taken, compare_result, prev_jump, dly, fp_control_status_m, n_mismatch, n_compared} = '0;
    rst = 1'b1;
    wb_sel_i = 4'hf;
    seed = 32'h0c809f15;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk(OFS_FP_CSR, FP_CONTROL_STATUS_RST);
    rdchk(OFS_CORE_CTRL, {30'h0, CTRL_RST});
    rdchk(OFS_CFG_FIRST, (32'h1 << CFG1_FPU_BIT) | (32'h1 << CFG1_COP2_BIT));
    rdchk(OFS_CFG_THIRD, 32'h0);
    w = (32'h1 << FIR_S_BIT) | (32'h1 << FIR_D_BIT) | (32'h1 << FIR_PAIRED_BIT) | (32'h1 << FIR_W_BIT);
    w = w | (32'h1 << FIR_L_BIT);
    wb(1'b1, OFS_FP_IMPL, $random(seed), r);
    rdchk(OFS_FP_IMPL, w);
    wb(1'b1, 5'h18, $random(seed), r);
    rdchk(5'h18, 32'h0);
    $display("test registers done");
    fp_control_status_m = $random(seed);
    wb(1'b1, OFS_FP_CSR, fp_control_status_m, r);
    for (int c = 0; c < 8; c++)
    begin
      w = $random(seed);
      issue({11'h0, 3'(c), 12'h0, 6'h21}, c[0] ? {{32{w[31]}}, w} : {32'($random(seed)), w}, 1'b0, 1'b0, 8'h00);
    end
    for (int c = 0; c < 8; c++)
      issue({6'h11, 5'h10, 10'h0, 3'(c), 2'b0, 6'h30}, 64'h0, 1'b0, 1'($random(seed)), 8'h00);
    idle();
    rdchk(OFS_FP_CSR, fp_control_status_m);
    $display("test condition codes done");
    for (int k = 0; k < 4; k++)
    begin
      issue(jt[k], 64'h0, 1'b0, 1'b0, 8'h00);
      issue(32'h0000_0021, 64'h0, 1'b0, 1'b0, 8'h00);
      issue(32'h0000_0021, 64'h0, 1'b0, 1'b0, 8'h00);
    end
    issue(32'h5000_0000, 64'h0, 1'b0, 1'b0, 8'h00);
    issue(32'h4a00_0001, 64'h0, 1'b1, 1'b0, 8'h00);
    issue(32'h5000_0000, 64'h0, 1'b0, 1'b0, 8'h00);
    issue(32'h4a00_0001, 64'h0, 1'b0, 1'b0, 8'h00);
    $display("test jump slots and nullify done");
    issue(32'h7800_0000, 64'h0, 1'b0, 1'b0, {1'b1, EXC_RI, 2'd0});
    issue(32'h7000_0003, 64'h0, 1'b0, 1'b0, {1'b1, EXC_RI, 2'd0});
    issue(32'h0000_080f, 64'h0, 1'b0, 1'b0, {1'b1, EXC_RI, 2'd0});
    issue(32'h7000_0002, 64'h0, 1'b0, 1'b0, 8'h00);
    issue(32'h46c0_0000, 64'h0, 1'b0, 1'b0, 8'h00);
    idle();
    wb(1'b1, OFS_CORE_CTRL, 32'h0, r);
    issue(32'h4600_0030, 64'h0, 1'b0, 1'b1, {1'b1, EXC_CPU, 2'd1});
    issue(32'h4a00_0001, 64'h0, 1'b0, 1'b0, {1'b1, EXC_CPU, 2'd2});
    idle();
    wb(1'b1, OFS_CORE_CTRL, 32'h3, r);
    rdchk(OFS_CORE_STAT, {19'h0, EXC_CPU, 8'h0});
    chk("cop2 function", u_partner.last_func[2], 32'h1);
    rdchk(OFS_FP_CSR, fp_control_status_m);
    $display("test exceptions done");
    for (int d = 0; d < 2; d++)
    begin
      dly <= 4'(d * 5);
      issue({21'h0, 5'($random(seed)), 6'h0f}, 64'h0, 1'b0, 1'b0, 8'h00);
      issue(32'h0000_0021, 64'h0, 1'b0, 1'b0, 8'h00);
    end
    idle();
    chk("results outstanding", q.size(), 32'h0);
    $display("test sync done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
